// file: include/bcr_defines.svh
// Constants for the banked core register file.
`ifndef BCR_DEFINES_SVH
`define BCR_DEFINES_SVH
`define BCR_MODE_USR   5'h10
`define BCR_MODE_FIQ   5'h11
`define BCR_MODE_IRQ   5'h12
`define BCR_MODE_SVC   5'h13
`define BCR_MODE_ABT   5'h17
`define BCR_MODE_UND   5'h1B
`define BCR_MODE_SYS   5'h1F
`define BCR_PSR_T_BIT  5
`define BCR_PSR_F_BIT  6
`define BCR_PSR_I_BIT  7
`define BCR_PSR_RESET  32'h000000D3
`define BCR_RESET_VEC  32'h00000000
`define BCR_REG_SP     4'hD
`define BCR_REG_LR     4'hE
`define BCR_REG_PC     4'hF
`endif

// file: include/bcr_pkg.sv
// Types for the banked core register file.
package bcr_pkg;
  typedef enum logic [6:0] {
    BANK_USR = 7'h01,
    BANK_FIQ = 7'h02,
    BANK_IRQ = 7'h04,
    BANK_SVC = 7'h08,
    BANK_ABT = 7'h10,
    BANK_UND = 7'h20,
    BANK_ILL = 7'h40
  } bcr_bank_t;

  typedef enum logic [3:0] {
    OP_NONE  = 4'h1,
    OP_WRITE = 4'h2,
    OP_BXCH  = 4'h4,
    OP_EXC   = 4'h8
  } bcr_op_t;

  typedef struct packed {
    logic [30:0][31:0] gpr;
    logic [31:0]       current_status_reg;
    logic [4:0][31:0]  saved_status_reg;
    logic [31:0]       pc;
    logic              bigend;
  } bcr_state_t;
endpackage : bcr_pkg

// file: logic/bcr_core_regs.sv
// Banked core register file with state, mode and byte-order handling.
`timescale 1ns/1ps
`default_nettype none
`include "bcr_defines.svh"

module bcr_core_regs #(
  parameter int DATA_W = 32
) (
  // Clock and reset.
  input  wire logic              MCLK_IN,
  input  wire logic              SYS_RST_IN,
  // Register read ports.
  input  wire logic [3:0]        RD_A_SEL_IN,
  input  wire logic [3:0]        RD_B_SEL_IN,
  input  wire logic              RD_HI_OK_IN,
  output logic [31:0]            RD_A_DATA_OUT,
  output logic [31:0]            RD_B_DATA_OUT,
  // Register write and control operations.
  input  wire logic              WR_EN_IN,
  input  wire logic [3:0]        WR_SEL_IN,
  input  wire logic [31:0]       WR_DATA_IN,
  input  wire logic              WR_HI_OK_IN,
  input  wire logic              PC_LOAD_IN,
  input  wire logic [31:0]       PC_DATA_IN,
  input  wire logic              PC_ADVANCE_IN,
  input  wire logic              BRANCH_WITH_LINK_IN,
  input  wire logic              STATE_EXCHANGE_BRANCH_IN,
  input  wire logic [31:0]       XCHG_OPERAND_IN,
  input  wire logic              EXC_TAKE_IN,
  input  wire logic [4:0]        EXC_MODE_IN,
  input  wire logic [31:0]       EXC_VECTOR_IN,
  input  wire logic [31:0]       EXC_LINK_IN,
  input  wire logic              EXC_RETURN_IN,
  input  wire logic              CURRENT_STATUS_REG_WR_IN,
  input  wire logic [31:0]       CURRENT_STATUS_REG_DATA_IN,
  input  wire logic              SAVED_STATUS_REG_WR_IN,
  input  wire logic [31:0]       SAVED_STATUS_REG_DATA_IN,
  // Configuration.
  input  wire logic              BYTE_ORDER_BIG_IN,
  // Instruction fetch.
  input  wire logic [31:0]       FETCH_WORD_IN,
  output logic [31:0]            FETCH_ADDR_OUT,
  output logic [31:0]            INSTR_OUT,
  // Memory data lanes.
  input  wire logic [31:0]       MEM_ADDR_IN,
  input  wire logic [1:0]        MEM_SIZE_IN,
  input  wire logic [31:0]       MEM_RDATA_IN,
  input  wire logic [31:0]       MEM_WDATA_IN,
  output logic [31:0]            LOAD_DATA_OUT,
  output logic [31:0]            STORE_LANES_OUT,
  output logic [3:0]             BYTE_EN_OUT,
  output logic                   MISALIGN_OUT,
  // Status.
  output logic [31:0]            CURRENT_STATUS_REG_OUT,
  output logic [31:0]            SAVED_STATUS_REG_OUT,
  output logic [4:0]             MODE_OUT,
  output logic                   PRIVILEGED_OUT,
  output logic                   MODE_ILLEGAL_OUT,
  output logic                   NARROW_STATE_OUT,
  output logic                   BIGEND_OUT
);

  // Banked storage and the byte lanes are laid out for 32-bit words only.
  if (DATA_W != 32) begin : g_width_check
    $error("bcr_core_regs serves a 32-bit datapath only.");
  end

  bcr_pkg::bcr_state_t st_ff;
  bcr_pkg::bcr_state_t nxt_st;
  bcr_pkg::bcr_bank_t  bank;
  logic                narrow;

  // Physical index map: 0-15 shared r0-r14 plus spare, 16-22 fiq r8-r14,
  // 23-30 irq/svc/abt/und r13-r14 pairs.
  // mode decode
  function automatic bcr_pkg::bcr_bank_t mode_bank(input logic [4:0] m);
    if (m == `BCR_MODE_USR || m == `BCR_MODE_SYS) begin
      mode_bank = bcr_pkg::BANK_USR;
    end else if (m == `BCR_MODE_FIQ) begin
      mode_bank = bcr_pkg::BANK_FIQ;
    end else if (m == `BCR_MODE_IRQ) begin
      mode_bank = bcr_pkg::BANK_IRQ;
    end else if (m == `BCR_MODE_SVC) begin
      mode_bank = bcr_pkg::BANK_SVC;
    end else if (m == `BCR_MODE_ABT) begin
      mode_bank = bcr_pkg::BANK_ABT;
    end else if (m == `BCR_MODE_UND) begin
      mode_bank = bcr_pkg::BANK_UND;
    end else begin
      mode_bank = bcr_pkg::BANK_ILL;
    end
  endfunction : mode_bank

  function automatic logic [4:0] phys_idx(input bcr_pkg::bcr_bank_t b, input logic [3:0] r);
    phys_idx = {1'b0, r};
    case (b)
      bcr_pkg::BANK_FIQ: begin
        if (r >= 4'h8) begin
          phys_idx = 5'(5'h10 + {1'b0, r} - 5'h08);
        end
      end
      bcr_pkg::BANK_IRQ: begin
        if (r == `BCR_REG_SP || r == `BCR_REG_LR) begin
          phys_idx = 5'(5'h17 + {4'h0, r[0]});
        end
      end
      bcr_pkg::BANK_SVC: begin
        if (r == `BCR_REG_SP || r == `BCR_REG_LR) begin
          phys_idx = 5'(5'h19 + {4'h0, r[0]});
        end
      end
      bcr_pkg::BANK_ABT: begin
        if (r == `BCR_REG_SP || r == `BCR_REG_LR) begin
          phys_idx = 5'(5'h1B + {4'h0, r[0]});
        end
      end
      bcr_pkg::BANK_UND: begin
        if (r == `BCR_REG_SP || r == `BCR_REG_LR) begin
          phys_idx = 5'(5'h1D + {4'h0, r[0]});
        end
      end
      default: begin
      end
    endcase
  endfunction : phys_idx

  // Saved status slot per exception mode; user and system have none.
  function automatic logic [2:0] saved_slot(input bcr_pkg::bcr_bank_t b);
    case (b)
      bcr_pkg::BANK_FIQ: saved_slot = 3'h0;
      bcr_pkg::BANK_IRQ: saved_slot = 3'h1;
      bcr_pkg::BANK_SVC: saved_slot = 3'h2;
      bcr_pkg::BANK_ABT: saved_slot = 3'h3;
      bcr_pkg::BANK_UND: saved_slot = 3'h4;
      default:           saved_slot = 3'h7;
    endcase
  endfunction : saved_slot

  function automatic logic [31:0] read_reg(input bcr_pkg::bcr_state_t s,
                                           input bcr_pkg::bcr_bank_t b,
                                           input logic nar, input logic [3:0] r);
    if (r == `BCR_REG_PC) begin
      read_reg = nar ? {s.pc[31:1], 1'b0} : {s.pc[31:2], 2'h0};
    end else begin
      read_reg = s.gpr[phys_idx(b, r)];
    end
  endfunction : read_reg

  assign bank   = mode_bank(st_ff.current_status_reg[4:0]);
  assign narrow = st_ff.current_status_reg[`BCR_PSR_T_BIT];

  // Narrow-state reads of high registers return zero unless a special move asks.
  // high register gate
  always_comb begin
    RD_A_DATA_OUT = 32'h00000000;
    RD_B_DATA_OUT = 32'h00000000;
    if (!narrow || !RD_A_SEL_IN[3] || RD_HI_OK_IN) begin
      RD_A_DATA_OUT = read_reg(st_ff, bank, narrow, RD_A_SEL_IN);
    end
    if (!narrow || !RD_B_SEL_IN[3] || RD_HI_OK_IN) begin
      RD_B_DATA_OUT = read_reg(st_ff, bank, narrow, RD_B_SEL_IN);
    end
  end

  always_comb begin
    bcr_pkg::bcr_bank_t eb;
    logic [2:0]         si;
    eb     = mode_bank(EXC_MODE_IN);
    si     = saved_slot(bank);
    nxt_st = st_ff;
    nxt_st.bigend = BYTE_ORDER_BIG_IN;
    if (PC_ADVANCE_IN) begin
      if (narrow) begin
        nxt_st.pc = st_ff.pc + 32'h00000002;
      end else begin
        nxt_st.pc = st_ff.pc + 32'h00000004;
      end
    end
    if (WR_EN_IN && (!narrow || !WR_SEL_IN[3] || WR_HI_OK_IN)) begin
      if (WR_SEL_IN == `BCR_REG_PC) begin
        nxt_st.pc = WR_DATA_IN;
      end else begin
        nxt_st.gpr[phys_idx(bank, WR_SEL_IN)] = WR_DATA_IN;
      end
    end
    if (PC_LOAD_IN) begin
      nxt_st.pc = PC_DATA_IN;
    end
    // The link takes the address held before any update in this same cycle.
    // branch link
    if (BRANCH_WITH_LINK_IN) begin
      nxt_st.gpr[phys_idx(bank, `BCR_REG_LR)] = st_ff.pc;
    end
    if (CURRENT_STATUS_REG_WR_IN) begin
      nxt_st.current_status_reg = CURRENT_STATUS_REG_DATA_IN;
    end
    // User and system modes own no saved copy, so such writes are dropped.
    if (SAVED_STATUS_REG_WR_IN && si != 3'h7) begin
      nxt_st.saved_status_reg[si] = SAVED_STATUS_REG_DATA_IN;
    end
    // Only the state bit and the pc move; mode bits and registers stay put.
    // state only
    if (STATE_EXCHANGE_BRANCH_IN) begin
      nxt_st.current_status_reg[`BCR_PSR_T_BIT] = XCHG_OPERAND_IN[0];
      if (XCHG_OPERAND_IN[0]) begin
        nxt_st.pc = {XCHG_OPERAND_IN[31:1], 1'b0};
      end else begin
        nxt_st.pc = {XCHG_OPERAND_IN[31:2], 2'h0};
      end
    end
    if (EXC_RETURN_IN && si != 3'h7) begin
      nxt_st.current_status_reg = st_ff.saved_status_reg[si];
    end
    // Entry runs last so that its pc, link, mode and status bits override other requests of the same cycle.
    // exception entry
    if (EXC_TAKE_IN && eb != bcr_pkg::BANK_ILL && eb != bcr_pkg::BANK_USR) begin
      nxt_st.saved_status_reg[saved_slot(eb)] = st_ff.current_status_reg;
      nxt_st.gpr[phys_idx(eb, `BCR_REG_LR)] = EXC_LINK_IN;
      nxt_st.current_status_reg[4:0] = EXC_MODE_IN;
      nxt_st.current_status_reg[`BCR_PSR_T_BIT] = 1'b0;
      nxt_st.current_status_reg[`BCR_PSR_I_BIT] = 1'b1;
      if (EXC_MODE_IN == `BCR_MODE_FIQ) begin
        nxt_st.current_status_reg[`BCR_PSR_F_BIT] = 1'b1;
      end
      nxt_st.pc = EXC_VECTOR_IN;
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (SYS_RST_IN) begin
      st_ff                    <= '0;
      st_ff.current_status_reg <= `BCR_PSR_RESET;
      st_ff.pc                 <= `BCR_RESET_VEC;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // In big-endian order the lower halfword address sits on the upper data lines.
  // halfword select
  always_comb begin
    FETCH_ADDR_OUT = {st_ff.pc[31:2], 2'h0};
    if (narrow) begin
      INSTR_OUT = st_ff.pc[1] ^ st_ff.bigend ? {16'h0000, FETCH_WORD_IN[31:16]}
                                            : {16'h0000, FETCH_WORD_IN[15:0]};
    end else begin
      INSTR_OUT = FETCH_WORD_IN;
    end
  end

  // A misaligned halfword or word is flagged only; it is never split into two accesses.
  // byte lanes
  always_comb begin
    logic [1:0] lane;
    logic [5:0] sh;
    lane = st_ff.bigend ? ~MEM_ADDR_IN[1:0] : MEM_ADDR_IN[1:0];
    sh   = {lane, 3'h0};
    LOAD_DATA_OUT   = 32'h00000000;
    STORE_LANES_OUT = 32'h00000000;
    BYTE_EN_OUT     = 4'h0;
    MISALIGN_OUT    = 1'b0;
    case (MEM_SIZE_IN)
      2'h0: begin
        LOAD_DATA_OUT   = {24'h000000, 8'(MEM_RDATA_IN >> sh)};
        STORE_LANES_OUT = {4{MEM_WDATA_IN[7:0]}};
        BYTE_EN_OUT     = 4'(4'h1 << lane);
      end
      2'h1: begin
        MISALIGN_OUT = MEM_ADDR_IN[0];
        lane = st_ff.bigend ? {~MEM_ADDR_IN[1], 1'b0} : {MEM_ADDR_IN[1], 1'b0};
        sh   = {lane, 3'h0};
        LOAD_DATA_OUT   = {16'h0000, 16'(MEM_RDATA_IN >> sh)};
        STORE_LANES_OUT = {2{MEM_WDATA_IN[15:0]}};
        BYTE_EN_OUT     = 4'(4'h3 << lane);
      end
      default: begin
        MISALIGN_OUT    = |MEM_ADDR_IN[1:0];
        LOAD_DATA_OUT   = MEM_RDATA_IN;
        STORE_LANES_OUT = MEM_WDATA_IN;
        BYTE_EN_OUT     = 4'hF;
      end
    endcase
  end

  always_comb begin
    logic [2:0] si;
    si                     = saved_slot(bank);
    CURRENT_STATUS_REG_OUT = st_ff.current_status_reg;
    SAVED_STATUS_REG_OUT   = (si != 3'h7) ? st_ff.saved_status_reg[si] : 32'h00000000;
    MODE_OUT               = st_ff.current_status_reg[4:0];
    // An illegal mode code is no mode at all, so it is never reported as privileged.
    MODE_ILLEGAL_OUT       = (bank == bcr_pkg::BANK_ILL);
    PRIVILEGED_OUT         = (MODE_OUT != `BCR_MODE_USR) && !MODE_ILLEGAL_OUT;
    NARROW_STATE_OUT       = narrow;
    BIGEND_OUT             = st_ff.bigend;
  end

endmodule : bcr_core_regs
`default_nettype wire

// file: sim/bcr_core_regs_sva.sv
// Port-level assertions for the banked core register file.
`timescale 1ns/1ps
`default_nettype none
module bcr_chk (
  // Clock, reset and requests.
  input wire logic        MCLK_IN,
  input wire logic        SYS_RST_IN,
  input wire logic        STATE_EXCHANGE_BRANCH_IN,
  input wire logic        CURRENT_STATUS_REG_WR_IN,
  input wire logic [31:0] XCHG_OPERAND_IN,
  input wire logic        EXC_TAKE_IN,
  input wire logic [4:0]  EXC_MODE_IN,
  input wire logic [31:0] EXC_VECTOR_IN,
  input wire logic        EXC_RETURN_IN,
  input wire logic        BYTE_ORDER_BIG_IN,
  input wire logic [31:0] MEM_ADDR_IN,
  input wire logic [1:0]  MEM_SIZE_IN,
  // Observed state.
  input wire logic [3:0]  BYTE_EN_OUT,
  input wire logic [31:0] FETCH_ADDR_OUT,
  input wire logic [31:0] CURRENT_STATUS_REG_OUT,
  input wire logic [31:0] SAVED_STATUS_REG_OUT,
  input wire logic [4:0]  MODE_OUT,
  input wire logic        PRIVILEGED_OUT,
  input wire logic        NARROW_STATE_OUT,
  input wire logic        BIGEND_OUT
);
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  // Later requests in one cycle override earlier ones, so a request is judged only when no later request shares its cycle.
  sequence s_xchg;
    STATE_EXCHANGE_BRANCH_IN && !EXC_TAKE_IN && !EXC_RETURN_IN && !CURRENT_STATUS_REG_WR_IN;
  endsequence
  sequence s_exc;
    EXC_TAKE_IN && EXC_MODE_IN inside {5'h11, 5'h12, 5'h13, 5'h17, 5'h1B};
  endsequence
  sequence s_ret;
    EXC_RETURN_IN && !EXC_TAKE_IN && MODE_OUT inside {5'h11, 5'h12, 5'h13, 5'h17, 5'h1B};
  endsequence
  property p_xnar;
    s_xchg ##0 XCHG_OPERAND_IN[0] |=> NARROW_STATE_OUT && $stable(MODE_OUT);
  endproperty
  a_xnar: assert property (p_xnar) else $error("narrow entry missed");
  property p_xwide;
    s_xchg ##0 !XCHG_OPERAND_IN[0] |=> !NARROW_STATE_OUT;
  endproperty
  a_xwide: assert property (p_xwide) else $error("wide entry missed");
  property p_exc;
    s_exc |=> !NARROW_STATE_OUT && MODE_OUT == $past(EXC_MODE_IN)
      && FETCH_ADDR_OUT == ($past(EXC_VECTOR_IN) & 32'hFFFFFFFC);
  endproperty
  a_exc: assert property (p_exc) else $error("exception entry wrong");
  property p_ret;
    s_ret |=> CURRENT_STATUS_REG_OUT == $past(SAVED_STATUS_REG_OUT);
  endproperty
  a_ret: assert property (p_ret) else $error("status restore wrong");
  property p_bend;
    !$past(SYS_RST_IN) |-> BIGEND_OUT == $past(BYTE_ORDER_BIG_IN);
  endproperty
  a_bend: assert property (p_bend) else $error("byte order output wrong");
  property p_narrow_state_out;
    NARROW_STATE_OUT == CURRENT_STATUS_REG_OUT[5];
  endproperty
  a_narrow_state_out: assert property (p_narrow_state_out) else $error("state output mismatch");
  property p_priv;
    PRIVILEGED_OUT == (MODE_OUT inside {5'h11, 5'h12, 5'h13, 5'h17, 5'h1B, 5'h1F});
  endproperty
  a_priv: assert property (p_priv) else $error("privilege flag wrong");
  property p_lane;
    MEM_SIZE_IN == 2'h0 |-> BYTE_EN_OUT ==
      (BIGEND_OUT ? 4'h8 >> MEM_ADDR_IN[1:0] : 4'h1 << MEM_ADDR_IN[1:0]);
  endproperty
  a_lane: assert property (p_lane) else $error("byte lane wrong");
endmodule : bcr_chk
bind bcr_core_regs bcr_chk u_chk (.*);
`default_nettype wire

// file: sim/tb.sv
// Self-checking bench for the banked core register file.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        MCLK_IN, SYS_RST_IN, RD_HI_OK_IN, WR_EN_IN, WR_HI_OK_IN, PC_LOAD_IN;
  logic        PC_ADVANCE_IN, BRANCH_WITH_LINK_IN, STATE_EXCHANGE_BRANCH_IN, EXC_TAKE_IN;
  logic        EXC_RETURN_IN, CURRENT_STATUS_REG_WR_IN, SAVED_STATUS_REG_WR_IN;
  logic        BYTE_ORDER_BIG_IN, MISALIGN_OUT, PRIVILEGED_OUT;
  logic        MODE_ILLEGAL_OUT, NARROW_STATE_OUT, BIGEND_OUT;
  logic [1:0]  MEM_SIZE_IN;
  logic [3:0]  RD_A_SEL_IN, RD_B_SEL_IN, WR_SEL_IN, BYTE_EN_OUT;
  logic [4:0]  EXC_MODE_IN, MODE_OUT;
  logic [31:0] RD_A_DATA_OUT, RD_B_DATA_OUT, WR_DATA_IN, PC_DATA_IN, XCHG_OPERAND_IN;
  logic [31:0] EXC_VECTOR_IN, EXC_LINK_IN, CURRENT_STATUS_REG_DATA_IN, FETCH_WORD_IN;
  logic [31:0] SAVED_STATUS_REG_DATA_IN, FETCH_ADDR_OUT, INSTR_OUT, MEM_ADDR_IN;
  logic [31:0] MEM_RDATA_IN, MEM_WDATA_IN, LOAD_DATA_OUT, STORE_LANES_OUT;
  logic [31:0] CURRENT_STATUS_REG_OUT, SAVED_STATUS_REG_OUT;
  int          error_cnt = 0;
  int          num_checks = 0;
  int          cyc = 0;
  logic [4:0]  modes [8] = '{5'h10, 5'h11, 5'h12, 5'h13, 5'h17, 5'h1B, 5'h1F, 5'h15};

  bcr_core_regs DUT (.*);

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Strobes drop at the edge that takes them, so no request is ever taken twice.
  task automatic go();
    @(posedge MCLK_IN);
    {WR_EN_IN, PC_LOAD_IN, PC_ADVANCE_IN, BRANCH_WITH_LINK_IN} <= '0;
    {STATE_EXCHANGE_BRANCH_IN, EXC_TAKE_IN, EXC_RETURN_IN} <= '0;
    {CURRENT_STATUS_REG_WR_IN, SAVED_STATUS_REG_WR_IN} <= '0;
    #1;
  endtask : go

  task automatic wr(input logic [3:0] r, input logic [31:0] d, input logic hi);
    @(posedge MCLK_IN);
    WR_EN_IN <= 1'h1;
    WR_SEL_IN <= r;
    WR_DATA_IN <= d;
    WR_HI_OK_IN <= hi;
    go();
  endtask : wr

  task automatic rd(input logic [3:0] r, input logic hi, input logic [31:0] exp);
    @(posedge MCLK_IN);
    RD_A_SEL_IN <= r;
    RD_B_SEL_IN <= r;
    RD_HI_OK_IN <= hi;
    #1;
    chk(RD_A_DATA_OUT, exp);
    chk(RD_B_DATA_OUT, exp);
  endtask : rd

  task automatic xb(input logic [31:0] op);
    @(posedge MCLK_IN);
    STATE_EXCHANGE_BRANCH_IN <= 1'h1;
    XCHG_OPERAND_IN <= op;
    go();
  endtask : xb

  task automatic ex(input logic [4:0] m, input logic [31:0] v, input logic [31:0] l);
    @(posedge MCLK_IN);
    EXC_TAKE_IN <= 1'h1;
    EXC_MODE_IN <= m;
    EXC_VECTOR_IN <= v;
    EXC_LINK_IN <= l;
    go();
  endtask : ex

  task automatic ret();
    @(posedge MCLK_IN);
    EXC_RETURN_IN <= 1'h1;
    go();
  endtask : ret

  initial begin
    MCLK_IN = 1'h0;
    forever #50 MCLK_IN = ~MCLK_IN;
  end

  always @(posedge MCLK_IN) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      error_cnt++;
      stop_test();
    end
  end

  initial begin
    {RD_HI_OK_IN, WR_EN_IN, WR_HI_OK_IN, PC_LOAD_IN, PC_ADVANCE_IN} = '0;
    {BRANCH_WITH_LINK_IN, STATE_EXCHANGE_BRANCH_IN, EXC_TAKE_IN, EXC_RETURN_IN} = '0;
    {CURRENT_STATUS_REG_WR_IN, SAVED_STATUS_REG_WR_IN} = '0;
    {BYTE_ORDER_BIG_IN, MEM_SIZE_IN, RD_A_SEL_IN, RD_B_SEL_IN, WR_SEL_IN, EXC_MODE_IN} = '0;
    {WR_DATA_IN, PC_DATA_IN, XCHG_OPERAND_IN, EXC_VECTOR_IN, EXC_LINK_IN} = '0;
    {CURRENT_STATUS_REG_DATA_IN, SAVED_STATUS_REG_DATA_IN, MEM_ADDR_IN} = '0;
    FETCH_WORD_IN = 32'hAAAABBBB;
    MEM_RDATA_IN = 32'h44332211;
    MEM_WDATA_IN = 32'h000000A5;
    SYS_RST_IN = 1'h1;
    repeat (4) @(posedge MCLK_IN);
    SYS_RST_IN <= 1'h0;
    #1;
    chk(CURRENT_STATUS_REG_OUT, 32'hD3);
    $display("reset test done");
    wr(4'h0, 32'h12345678, 1'h0);
    wr(4'h8, 32'h88, 1'h0);
    wr(4'hD, 32'h5000, 1'h0);
    xb(32'h101);
    chk(MODE_OUT, 32'h13);
    chk(CURRENT_STATUS_REG_OUT, 32'hF3);
    rd(4'h0, 1'h0, 32'h12345678);
    rd(4'hD, 1'h1, 32'h5000);
    rd(4'hF, 1'h1, 32'h100);
    rd(4'h8, 1'h0, 32'h0);
    chk({16'h0, INSTR_OUT[15:0]}, 32'hBBBB);
    @(posedge MCLK_IN);
    PC_ADVANCE_IN <= 1'h1;
    go();
    chk({16'h0, INSTR_OUT[15:0]}, 32'hAAAA);
    chk(FETCH_ADDR_OUT, 32'h100);
    rd(4'hF, 1'h1, 32'h102);
    wr(4'h8, 32'h77, 1'h0);
    rd(4'h8, 1'h1, 32'h88);
    wr(4'h9, 32'h99, 1'h1);
    rd(4'h9, 1'h1, 32'h99);
    $display("state test done");
    ex(5'h12, 32'h18, 32'h106);
    chk(CURRENT_STATUS_REG_OUT, 32'hD2);
    chk(SAVED_STATUS_REG_OUT, 32'hF3);
    rd(4'hE, 1'h0, 32'h106);
    rd(4'hD, 1'h0, 32'h0);
    ret();
    chk(NARROW_STATE_OUT, 32'h1);
    rd(4'hD, 1'h1, 32'h5000);
    xb(32'h200);
    @(posedge MCLK_IN);
    PC_LOAD_IN <= 1'h1;
    PC_DATA_IN <= 32'h300;
    go();
    @(posedge MCLK_IN);
    BRANCH_WITH_LINK_IN <= 1'h1;
    go();
    rd(4'hE, 1'h0, 32'h300);
    ex(5'h11, 32'h1C, 32'h0);
    chk(CURRENT_STATUS_REG_OUT, 32'hD1);
    rd(4'h8, 1'h0, 32'h0);
    rd(4'h0, 1'h0, 32'h12345678);
    @(posedge MCLK_IN);
    SAVED_STATUS_REG_WR_IN <= 1'h1;
    SAVED_STATUS_REG_DATA_IN <= 32'h10;
    go();
    ret();
    chk(MODE_OUT, 32'h10);
    rd(4'h8, 1'h0, 32'h88);
    $display("exception test done");
    for (int i = 0; i < 8; i++) begin
      @(posedge MCLK_IN);
      CURRENT_STATUS_REG_WR_IN <= 1'h1;
      CURRENT_STATUS_REG_DATA_IN <= {27'h0, modes[i]};
      go();
      chk(MODE_ILLEGAL_OUT, 32'(i == 7));
      chk(PRIVILEGED_OUT, 32'(i != 0 && i != 7));
    end
    $display("mode test done");
    for (int b = 0; b < 2; b++) begin
      @(posedge MCLK_IN);
      BYTE_ORDER_BIG_IN <= b[0];
      go();
      chk(BIGEND_OUT, 32'(b));
      for (int a = 0; a < 4; a++) begin
        @(posedge MCLK_IN);
        MEM_ADDR_IN <= 32'(a);
        #1;
        chk(BYTE_EN_OUT, 32'(b ? 8 >> a : 1 << a));
        chk(LOAD_DATA_OUT, 32'((b ? 4 - a : a + 1) * 17));
        chk(STORE_LANES_OUT, 32'hA5A5A5A5);
      end
    end
    @(posedge MCLK_IN);
    MEM_SIZE_IN <= 2'h1;
    MEM_ADDR_IN <= 32'h2;
    #1;
    chk(LOAD_DATA_OUT, 32'h2211);
    chk(BYTE_EN_OUT, 32'h3);
    chk(STORE_LANES_OUT, 32'h00A500A5);
    chk(MISALIGN_OUT, 32'h0);
    @(posedge MCLK_IN);
    MEM_SIZE_IN <= 2'h2;
    MEM_ADDR_IN <= 32'h3;
    #1;
    chk(MISALIGN_OUT, 32'h1);
    $display("memory test done");
    stop_test();
  end
endmodule : tb
`default_nettype wire
